// >>> testbench.sv
// self-checking bench for the triple interval counter/timer
module testbench
  import tic_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys;
  logic rst_n;
  tic_io_s io_req;
  logic [7:0] io_rdata;
  logic [2:0] cnt_clk;
  logic [2:0] cnt_gate;
  logic [2:0] counter_out;
  logic conv_done_in;
  logic irq_req;
  int n_mismatch;
  int checks;
  int n_irq;
  int n_hi;
  logic [15:0] rd16;
  logic [7:0] rd8;

  tic_timer tic_timer_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .io_req(io_req), .io_rdata(io_rdata),
    .counter_clock_in(cnt_clk), .counter_gate_in(cnt_gate), .counter_out(counter_out),
    .conv_done_in(conv_done_in), .irq_req(irq_req)
  );

  tic_host tic_host_i (.clk_sys(clk_sys), .io_req(io_req), .io_rdata(io_rdata));

  // ------------------------------------------------------------
  // clock, irq pulse counter
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (irq_req === 1'b1) n_irq <= n_irq + 1;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // one count step: high one cycle, low the next, then room for the output update
  task automatic tick(input int k, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      cnt_clk[k] <= 1'b1;
      @(posedge clk_sys);
      cnt_clk[k] <= 1'b0;
      @(posedge clk_sys);
    end
    #1;
  endtask

  task automatic gate(input int k, input logic v);
    @(posedge clk_sys);
    cnt_gate[k] <= v;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // a hung run counts as a failure
  initial begin
    #600000;
    n_mismatch++;
    $display("mismatch at %0t: run did not finish", $time);
    end_of_test();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    cnt_clk = 3'h0;
    cnt_gate = 3'h6;
    conv_done_in = 1'b0;
    n_mismatch = 0;
    checks = 0;
    n_irq = 0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    chk_word({13'h0000, counter_out}, 16'h0007, "outputs after reset");
    chk_word({8'h00, io_rdata}, 16'h0000, "read data after reset");
    $display("test reset done");

    // terminal-count pulse: low on load, gate low pauses, high at zero and held
    tic_host_i.write_byte(OFF_CTL, 8'h30);
    tic_host_i.write_byte(OFF_DATA0, 8'h03);
    gate(0, 1'b1);
    tick(0, 3);
    chk_bit(counter_out[0], 1'b0, "lone low byte");
    tic_host_i.write_byte(OFF_DATA0, 8'h00);
    tick(0, 1);
    gate(0, 1'b0);
    tick(0, 4);
    chk_bit(counter_out[0], 1'b0, "gate low pause");
    gate(0, 1'b1);
    tick(0, 2);
    chk_bit(counter_out[0], 1'b0, "before zero");
    tick(0, 1);
    chk_bit(counter_out[0], 1'b1, "at zero");
    tick(0, 3);
    chk_bit(counter_out[0], 1'b1, "held after zero");
    $display("test terminal count done");

    // gated pulse measurement from full count, latched read while counting
    tic_host_i.program16(OFF_DATA0, 8'h30, 16'hffff);
    tick(0, 6);
    gate(0, 1'b0);
    tick(0, 3);
    tic_host_i.read16(OFF_DATA0, rd16);
    chk_word(rd16, 16'hfffa, "count held with gate low");
    tic_host_i.write_byte(OFF_CTL, 8'h00);
    gate(0, 1'b1);
    tick(0, 2);
    tic_host_i.read16(OFF_DATA0, rd16);
    chk_word(rd16, 16'hfffa, "latched count");
    tic_host_i.read16(OFF_DATA0, rd16);
    chk_word(rd16, 16'hfff8, "live count after latch");
    $display("test measure and latch done");

    // square wave on counter 1: odd and even divisors, two periods each
    for (int d = 4; d <= 5; d++) begin
      tic_host_i.program16(OFF_DATA1, 8'h76, 16'(d));
      tick(1, 1);
      n_hi = 0;
      repeat (2 * d) begin
        tick(1, 1);
        n_hi += int'(counter_out[1] === 1'b1);
      end
      chk_word(16'(n_hi), 16'(d + (d % 2)), "square high count");
    end
    $display("test square wave done");

    // counter 2 square wave raises one irq per rising output edge; converter done too
    tic_host_i.program16(OFF_DATA2, 8'hb6, 16'h0004);
    tick(2, 1);
    n_irq = 0;
    tick(2, 8);
    repeat (2) @(posedge clk_sys);
    #1;
    chk_word(16'(n_irq), 16'h0002, "counter 2 irq pulses");
    @(posedge clk_sys);
    conv_done_in <= 1'b1;
    @(posedge clk_sys);
    conv_done_in <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk_word(16'(n_irq), 16'h0003, "conversion done irq");
    $display("test interrupt done");

    // retriggerable one-shot on counter 0
    gate(0, 1'b0);
    tic_host_i.program16(OFF_DATA0, 8'h32, 16'h0003);
    gate(0, 1'b1);
    gate(0, 1'b0);
    tick(0, 1);
    chk_bit(counter_out[0], 1'b0, "one-shot triggered");
    tick(0, 2);
    chk_bit(counter_out[0], 1'b0, "gate fall keeps count");
    gate(0, 1'b1);
    tick(0, 3);
    chk_bit(counter_out[0], 1'b0, "retrigger restarts");
    tick(0, 1);
    chk_bit(counter_out[0], 1'b1, "one-shot timeout");
    tick(0, 4);
    chk_bit(counter_out[0], 1'b1, "held until trigger");
    $display("test one-shot done");

    // software then hardware strobe: one count period low at timeout
    for (int m = 0; m < 2; m++) begin
      gate(0, 1'b0);
      tic_host_i.program16(OFF_DATA0, m == 0 ? 8'h38 : 8'h3a, 16'h0002);
      gate(0, 1'b1);
      chk_bit(counter_out[0], 1'b1, "strobe high at start");
      tick(0, 2);
      chk_bit(counter_out[0], 1'b1, "strobe before timeout");
      tick(0, 1);
      chk_bit(counter_out[0], 1'b0, "strobe low");
      tick(0, 1);
      chk_bit(counter_out[0], 1'b1, "strobe one period");
    end
    $display("test strobes done");

    // rate generator on counter 1, then readback of its status and count
    tic_host_i.program16(OFF_DATA1, 8'h74, 16'h0003);
    tick(1, 3);
    chk_bit(counter_out[1], 1'b0, "rate low before reload");
    tick(1, 1);
    chk_bit(counter_out[1], 1'b1, "rate high after reload");
    tic_host_i.write_byte(OFF_CTL, 8'hc4);
    tick(1, 1);
    tic_host_i.read_byte(OFF_DATA1, rd8);
    chk_word({8'h00, rd8}, 16'h00b4, "latched status");
    tic_host_i.read16(OFF_DATA1, rd16);
    chk_word(rd16, 16'h0003, "readback latched count");
    tic_host_i.read16(OFF_DATA1, rd16);
    chk_word(rd16, 16'h0002, "live count after readback");
    $display("test rate and readback done");
    end_of_test();
  end
endmodule

// >>> tic_host.sv
// host-side model that writes and reads the byte-wide control and data ports
module tic_host
  import tic_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // host i/o port
  output tic_io_s io_req,
  input wire logic [7:0] io_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial io_req = '0;

  // ------------------------------------------------------------
  // single byte cycles
  // ------------------------------------------------------------
  // address and data are scrambled after each strobe, so a stale value never matches
  task automatic write_byte(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    io_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk_sys);
    io_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask

  task automatic read_byte(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    io_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk_sys);
    io_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hff};
    #1;
    d = io_rdata;
  endtask

  // ------------------------------------------------------------
  // counter programming
  // ------------------------------------------------------------
  // control byte first, then low byte and high byte
  task automatic program16(input logic [3:0] a, input logic [7:0] ctl, input logic [15:0] v);
    write_byte(OFF_CTL, ctl);
    write_byte(a, v[7:0]);
    write_byte(a, v[15:8]);
  endtask

  // paired reads, low byte first
  task automatic read16(input logic [3:0] a, output logic [15:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    read_byte(a, lo);
    read_byte(a, hi);
    v = {hi, lo};
  endtask
endmodule

// >>> tic_pkg.sv
// constants, carriers and helpers shared by the triple interval counter/timer
package tic_pkg;

  // ------------------------------------------------------------
  // port offsets on the byte-wide i/o bus
  // ------------------------------------------------------------
  localparam logic [3:0] OFF_DATA0 = 4'h8;
  localparam logic [3:0] OFF_DATA1 = 4'h9;
  localparam logic [3:0] OFF_DATA2 = 4'ha;
  localparam logic [3:0] OFF_CTL = 4'hb;
  localparam logic [1:0] PORT_PAGE = 2'h2;

  // ------------------------------------------------------------
  // control byte fields and codes
  // ------------------------------------------------------------
  localparam logic [1:0] SEL_READBACK = 2'h3;
  localparam logic [1:0] ACC_LATCH = 2'h0;
  localparam logic [1:0] ACC_LO = 2'h1;
  localparam logic [1:0] ACC_HI = 2'h2;
  localparam logic [1:0] ACC_PAIR = 2'h3;
  localparam logic [2:0] MODE_TC = 3'h0;
  localparam logic [2:0] MODE_ONESHOT = 3'h1;
  localparam logic [2:0] MODE_RATE = 3'h2;
  localparam logic [2:0] MODE_SQUARE = 3'h3;
  localparam logic [2:0] MODE_SWSTROBE = 3'h4;
  localparam logic [2:0] MODE_HWSTROBE = 3'h5;
  localparam int RB_CNT_BIT = 5;
  localparam int RB_STA_BIT = 4;
  localparam int RB_SEL_LSB = 1;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic OUT_RST = 1'b1;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [1:0] ACC_RST = ACC_PAIR;
  localparam logic [2:0] MODE_RST = MODE_TC;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic counter_select_high;
    logic counter_select_low;
    logic byte_access_high;
    logic byte_access_low;
    logic op_select_bit2;
    logic op_select_bit1;
    logic op_select_bit0;
    logic bcd;
  } tic_ctl_s;

  typedef struct packed {
    logic [3:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } tic_io_s;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // the top mode bit is a don't-care for modes 2 and 3
  function automatic logic [2:0] tic_norm_mode(input tic_ctl_s c);
    return c.op_select_bit1 ? {1'b0, c.op_select_bit1, c.op_select_bit0}
                            : {c.op_select_bit2, c.op_select_bit1, c.op_select_bit0};
  endfunction

  // odd divisors give the extra input period to the high half
  function automatic logic [15:0] tic_half(input logic [15:0] n, input logic high);
    logic [16:0] s;
    s = {1'b0, n} + {16'h0000, high};
    return s[16:1];
  endfunction

endpackage

// >>> tic_timer.sv
// three 16-bit down counters behind byte-wide control and data ports
// Function
// - square wave with odd divisor: one half longer by one input clock period
// - counters count downward; software subtracts remaining count from start value
// - terminal-count mode: output low on load, counting only while gate high
// - terminal-count mode: output high at zero, held until next count load
// - terminal-count mode: gate low suspends decrementing, resumes when gate high
// - one-shot: one load suffices, each gate rise starts cycle, output low
// - one-shot: gate fall keeps counting, new rise restarts from loaded count
// - one-shot: output high at zero until next gate trigger
// - software strobe: output high on load, one period low at timeout
// - hardware strobe: gate rise sets output high, retriggers, one period low
// - interrupt request on counter 2 timeout or converter end of conversion
// - control byte 0x76: counter 1, low-high access, square wave, binary
// - control byte 0xb6: counter 2, low-high access, square wave, binary
// - after 0x30, counter 0 takes low byte then high byte
// - counter 0 outside one-shot and hardware strobe decrements only while gate high, holds count when gate low
// - control byte: select bits top, access bits, mode bits, bcd at bit 0
// - two-byte access: loads and reads pair low then high via sequencer
// - square wave repeats, high first half of count, low second half
// - access bits zero latch current count; reads return it, counting undisturbed
module tic_timer
  import tic_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // host i/o port
  input wire tic_io_s io_req,
  output logic [7:0] io_rdata,
  // counter pins
  input wire logic [2:0] counter_clock_in,
  input wire logic [2:0] counter_gate_in,
  output logic [2:0] counter_out,
  // interrupt request
  input wire logic conv_done_in,
  output logic irq_req
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [15:0] cnt [3];
  logic [15:0] reload [3];
  logic [15:0] hold [3];
  logic [7:0] lo_buf [3];
  logic [7:0] stat [3];
  logic [1:0] cfg_acc [3];
  logic [2:0] cfg_mode [3];
  logic [2:0] cfg_bcd;
  logic [2:0] wseq, rseq, latched, stat_v;
  logic [2:0] nullc, trig, armed, have;
  logic [2:0] gate_q, clk_q;
  logic counter_two_output_q;
  logic pins_ok;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  tic_ctl_s cw;
  logic [1:0] cw_sel, cw_acc;
  logic [2:0] cw_mode;
  logic wr_ctl, cw_rb, rd_page, tc2_edge;
  logic [2:0] wr_dat, rd_dat, full_wr, ctl_prog, cnt_latch, stat_latch;
  logic [2:0] cken, grise, hold_hi;
  logic [15:0] wr_val [3];
  logic [7:0] rd_byte [4];

  assign cw = tic_ctl_s'(io_req.wdata);
  assign cw_sel = {cw.counter_select_high, cw.counter_select_low};
  assign cw_acc = {cw.byte_access_high, cw.byte_access_low};
  assign cw_mode = tic_norm_mode(cw);
  assign wr_ctl = io_req.wr && io_req.addr == OFF_CTL;
  assign cw_rb = cw_sel == SEL_READBACK;
  assign rd_page = io_req.rd && io_req.addr[3:2] == PORT_PAGE;
  // first sample after reset is never an edge, whatever level the pin rests at
  assign cken = counter_clock_in & ~clk_q & {3{pins_ok}};
  assign grise = counter_gate_in & ~gate_q & {3{pins_ok}};
  assign rd_byte[3] = 8'h00;

  for (genvar g = 0; g < 3; g++) begin : g_dec
    logic [15:0] src;
    logic hi_sel;
    assign wr_dat[g] = io_req.wr && io_req.addr == OFF_DATA0 + 4'(g);
    assign rd_dat[g] = io_req.rd && io_req.addr == OFF_DATA0 + 4'(g);
    assign full_wr[g] = wr_dat[g] && (cfg_acc[g] != ACC_PAIR || wseq[g]);
    assign wr_val[g] = cfg_acc[g] == ACC_PAIR ? {io_req.wdata, lo_buf[g]} :
                       cfg_acc[g] == ACC_HI ? {io_req.wdata, 8'h00} :
                       {8'h00, io_req.wdata};
    assign ctl_prog[g] = wr_ctl && cw_sel == 2'(g) && cw_acc != ACC_LATCH;
    assign cnt_latch[g] = wr_ctl && ((cw_sel == 2'(g) && cw_acc == ACC_LATCH) ||
        (cw_rb && !io_req.wdata[RB_CNT_BIT] && io_req.wdata[RB_SEL_LSB + g]));
    assign stat_latch[g] = wr_ctl && cw_rb && !io_req.wdata[RB_STA_BIT] &&
                           io_req.wdata[RB_SEL_LSB + g];
    assign hold_hi[g] = !counter_gate_in[g] &&
                        (cfg_mode[g] == MODE_RATE || cfg_mode[g] == MODE_SQUARE);
    assign src = latched[g] ? hold[g] : cnt[g];
    assign hi_sel = cfg_acc[g] == ACC_HI || (cfg_acc[g] == ACC_PAIR && rseq[g]);
    assign rd_byte[g] = stat_v[g] ? stat[g] : (hi_sel ? src[15:8] : src[7:0]);
  end

  // terminal count edge differs per mode: rising for 0, 1, 3, falling otherwise
  assign tc2_edge = (cfg_mode[2] == MODE_TC || cfg_mode[2] == MODE_ONESHOT ||
                     cfg_mode[2] == MODE_SQUARE) ? (counter_out[2] && !counter_two_output_q)
                                                 : (!counter_out[2] && counter_two_output_q);

  // ------------------------------------------------------------
  // host side: configuration, byte sequencing, latches
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata <= 8'h00;
      cfg_bcd <= '0;
      wseq <= '0;
      rseq <= '0;
      latched <= '0;
      stat_v <= '0;
      for (int i = 0; i < 3; i++) begin
        reload[i] <= CNT_RST;
        hold[i] <= CNT_RST;
        lo_buf[i] <= 8'h00;
        stat[i] <= 8'h00;
        cfg_acc[i] <= ACC_RST;
        cfg_mode[i] <= MODE_RST;
      end
    end else begin
      io_rdata <= rd_page ? rd_byte[io_req.addr[1:0]] : 8'h00;
      for (int i = 0; i < 3; i++) begin
        if (ctl_prog[i]) begin
          cfg_acc[i] <= cw_acc;
          cfg_mode[i] <= cw_mode;
          cfg_bcd[i] <= cw.bcd;
          wseq[i] <= 1'b0;
          rseq[i] <= 1'b0;
          latched[i] <= 1'b0;
          stat_v[i] <= 1'b0;
        end
        // a pending latch must be read out before another one counts
        if (cnt_latch[i] && !latched[i]) begin
          hold[i] <= cnt[i];
          latched[i] <= 1'b1;
        end
        if (stat_latch[i] && !stat_v[i]) begin
          stat[i] <= {counter_out[i], nullc[i], cfg_acc[i], cfg_mode[i], cfg_bcd[i]};
          stat_v[i] <= 1'b1;
        end
        if (wr_dat[i]) begin
          if (cfg_acc[i] == ACC_PAIR) begin
            wseq[i] <= !wseq[i];
          end
          if (!wseq[i]) begin
            lo_buf[i] <= io_req.wdata;
          end
          if (full_wr[i]) begin
            reload[i] <= wr_val[i];
          end
        end
        if (rd_dat[i]) begin
          if (stat_v[i]) begin
            stat_v[i] <= 1'b0;
          end else begin
            if (cfg_acc[i] == ACC_PAIR) begin
              rseq[i] <= !rseq[i];
            end
            if (cfg_acc[i] != ACC_PAIR || rseq[i]) begin
              latched[i] <= 1'b0;
            end
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // count engines, one step per counter clock edge
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gate_q <= '0;
      clk_q <= '0;
      counter_out <= {3{OUT_RST}};
      nullc <= '0;
      trig <= '0;
      armed <= '0;
      have <= '0;
      counter_two_output_q <= OUT_RST;
      pins_ok <= 1'b0;
      irq_req <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        cnt[i] <= CNT_RST;
      end
    end else begin
      gate_q <= counter_gate_in;
      clk_q <= counter_clock_in;
      counter_two_output_q <= counter_out[2];
      pins_ok <= 1'b1;
      irq_req <= tc2_edge || conv_done_in;
      for (int i = 0; i < 3; i++) begin
        if (ctl_prog[i]) begin
          counter_out[i] <= cw_mode != MODE_TC;
          nullc[i] <= 1'b0;
          trig[i] <= 1'b0;
          armed[i] <= 1'b0;
          have[i] <= 1'b0;
        end else if (full_wr[i]) begin
          nullc[i] <= 1'b1;
          have[i] <= 1'b1;
          if (cfg_mode[i] == MODE_TC) begin
            counter_out[i] <= 1'b0;
          end
        end else begin
          if (grise[i]) begin
            trig[i] <= 1'b1;
          end
          if (hold_hi[i]) begin
            counter_out[i] <= 1'b1;
          end
          if (cken[i]) begin
            unique case (cfg_mode[i])
              MODE_TC, MODE_SWSTROBE: begin
                if (cfg_mode[i] == MODE_SWSTROBE && !counter_out[i]) begin
                  counter_out[i] <= 1'b1;
                end
                if (nullc[i]) begin
                  cnt[i] <= reload[i];
                  nullc[i] <= 1'b0;
                  armed[i] <= 1'b1;
                end else if (counter_gate_in[i]) begin
                  cnt[i] <= cnt[i] - 16'h0001;
                  if (cnt[i] == 16'h0001 && armed[i]) begin
                    armed[i] <= 1'b0;
                    counter_out[i] <= cfg_mode[i] == MODE_TC;
                  end
                end
              end
              MODE_ONESHOT, MODE_HWSTROBE: begin
                if (cfg_mode[i] == MODE_HWSTROBE && !counter_out[i]) begin
                  counter_out[i] <= 1'b1;
                end
                // the trigger is consumed here, so a rise in this cycle is not lost
                if (have[i] && (trig[i] || grise[i])) begin
                  cnt[i] <= reload[i];
                  nullc[i] <= 1'b0;
                  armed[i] <= 1'b1;
                  trig[i] <= 1'b0;
                  counter_out[i] <= cfg_mode[i] == MODE_HWSTROBE;
                end else begin
                  cnt[i] <= cnt[i] - 16'h0001;
                  if (cnt[i] == 16'h0001 && armed[i]) begin
                    armed[i] <= 1'b0;
                    counter_out[i] <= cfg_mode[i] == MODE_ONESHOT;
                  end
                end
              end
              MODE_RATE, MODE_SQUARE: begin
                if (nullc[i] || trig[i] || grise[i]) begin
                  cnt[i] <= cfg_mode[i] == MODE_SQUARE ? tic_half(reload[i], 1'b1)
                                                       : reload[i];
                  nullc[i] <= 1'b0;
                  trig[i] <= 1'b0;
                  counter_out[i] <= 1'b1;
                end else if (counter_gate_in[i]) begin
                  if (cnt[i] == 16'h0001) begin
                    if (cfg_mode[i] == MODE_SQUARE) begin
                      counter_out[i] <= !counter_out[i];
                      cnt[i] <= tic_half(reload[i], !counter_out[i]);
                    end else begin
                      counter_out[i] <= 1'b1;
                      cnt[i] <= reload[i];
                    end
                  end else begin
                    cnt[i] <= cnt[i] - 16'h0001;
                    if (cfg_mode[i] == MODE_RATE && cnt[i] == 16'h0002) begin
                      counter_out[i] <= 1'b0;
                    end
                  end
                end
              end
            endcase
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_ctl_byte_one: assert property (
    wr_ctl && io_req.wdata == 8'h76 |=> cfg_mode[1] == MODE_SQUARE &&
    cfg_acc[1] == ACC_PAIR && !cfg_bcd[1]) else $error("0x76 decoded wrongly");
  a_ctl_byte_two: assert property (
    wr_ctl && io_req.wdata == 8'hb6 |=> cfg_mode[2] == MODE_SQUARE &&
    cfg_acc[2] == ACC_PAIR && !cfg_bcd[2]) else $error("0xb6 decoded wrongly");
  a_pair_load_order: assert property (
    wr_dat[0] && cfg_acc[0] == ACC_PAIR && wseq[0]
    |=> reload[0] == {$past(io_req.wdata), $past(lo_buf[0])}) else $error("pair load order");
  a_low_byte_only: assert property (
    wr_dat[0] && cfg_acc[0] == ACC_PAIR && !wseq[0] |=> $stable(reload[0]) && wseq[0])
    else $error("low byte alone changed the count");
  a_tc_load_low: assert property (
    full_wr[0] && cfg_mode[0] == MODE_TC |=> !counter_out[0]) else $error("no low on load");
  a_tc_stays_high: assert property (
    cfg_mode[0] == MODE_TC && counter_out[0] && !io_req.wr |=> counter_out[0])
    else $error("terminal count output dropped");
  a_gate_low_hold: assert property (
    cfg_mode[0] == MODE_TC && !counter_gate_in[0] && !nullc[0] && !io_req.wr
    |=> $stable(cnt[0])) else $error("count moved with gate low");
  a_count_down: assert property (
    cfg_mode[0] == MODE_TC && cken[0] && counter_gate_in[0] && !nullc[0] && !io_req.wr
    |=> cnt[0] == $past(cnt[0]) - 16'h0001) else $error("count did not decrement");
  a_oneshot_start: assert property (
    cfg_mode[0] == MODE_ONESHOT && cken[0] && have[0] && (trig[0] || grise[0]) &&
    !io_req.wr |=> !counter_out[0] && cnt[0] == reload[0]) else $error("one-shot start");
  a_oneshot_end: assert property (
    cfg_mode[0] == MODE_ONESHOT && cken[0] && armed[0] && cnt[0] == 16'h0001 &&
    !trig[0] && !grise[0] && !io_req.wr |=> counter_out[0]) else $error("one-shot end");
  a_strobe_width: assert property (
    (cfg_mode[0] == MODE_SWSTROBE || cfg_mode[0] == MODE_HWSTROBE) && !counter_out[0] &&
    cken[0] && !io_req.wr |=> counter_out[0]) else $error("strobe longer than one period");
  a_hw_retrigger: assert property (
    cfg_mode[0] == MODE_HWSTROBE && cken[0] && have[0] && (trig[0] || grise[0]) &&
    !io_req.wr
    |=> counter_out[0] && cnt[0] == reload[0]) else $error("hardware strobe retrigger");
  a_square_toggle: assert property (
    cfg_mode[1] == MODE_SQUARE && cken[1] && counter_gate_in[1] && cnt[1] == 16'h0001 &&
    !nullc[1] && !trig[1] && !grise[1] && !io_req.wr
    |=> counter_out[1] != $past(counter_out[1])) else $error("square wave did not toggle");
  a_latch_hold: assert property (
    cnt_latch[0] && !latched[0] |=> latched[0] && hold[0] == $past(cnt[0]))
    else $error("latch missed the count");
  a_irq_timeout: assert property (
    (cfg_mode[2] == MODE_TC || cfg_mode[2] == MODE_ONESHOT || cfg_mode[2] == MODE_SQUARE) &&
    !io_req.wr ##1 $rose(counter_out[2]) |=> irq_req)
    else $error("counter 2 timeout without request");
  a_sw_strobe_low: assert property (
    cfg_mode[0] == MODE_SWSTROBE && cken[0] && counter_gate_in[0] && !nullc[0] && armed[0] &&
    cnt[0] == 16'h0001 && !io_req.wr |=> !counter_out[0]) else $error("no strobe at timeout");
  a_irq_convert: assert property (
    conv_done_in |=> irq_req) else $error("conversion done without request");

endmodule
